// ===== rtl/pdl_pll_ctrl.sv
// Summary of operation
// RULE1 - Synthesizer write clears lock and oscillator status
// RULE2 - Locked loop runs at 2*ref*(multiplier+1)
// RULE3 - Software sets VCO range code per frequency
// RULE4 - Reference divider writable only unprotected, PLL selected
// RULE5 - Reference divider write clears lock, oscillator status
// RULE6 - Reference is external/(divider+1) or internal 1MHz
// RULE7 - Software sets reference range code per frequency
// RULE8 - Internal reference forces filter range to lowest
// RULE9 - Post divider writable only while PLL selected
// RULE10 - Output is loop/(post+1) locked, else loop/4
// RULE11 - Bus clock is half of PLL clock
// RULE12 - Post divider steps gradually, settles within 32
// RULE13 - Tick flag set per period, write-one clears
// RULE14 - Lock change flag set on lock toggle
// RULE15 - Lock bit is read-only tolerance mirror
// RULE16 - Oscillator change flag set on status toggle
// RULE17 - Oscillator status read-only, cleared on full stop
// RULE18 - Each flag requests interrupt only when enabled
// RULE19 - Oscillator loss or full stop forces PLL select
// RULE20 - Unused flag bits read zero, ignore writes
`default_nettype none
module pdl_pll_ctrl
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Analog loop and clock unit
    input  wire logic        loop_in_tol,
    input  wire logic        osc_good,
    input  wire logic        tick_end,
    input  wire logic        full_stop_entry,
    // Status and configuration out
    output logic             pll_locked,
    output logic             osc_qualified,
    output logic             sysclk_from_pll,
    output logic             cfg_write_lock,
    output logic             ext_osc_enable,
    output logic      [1:0]  vco_range_sel,
    output logic      [7:0]  vco_mult,
    output logic      [4:0]  ref_div_ratio,
    output logic      [1:0]  ref_filter_range,
    output logic      [5:0]  pll_post_ratio,
    output logic      [6:0]  bus_ratio,
    // Interrupt requests
    output logic             tick_irq,
    output logic             lock_irq,
    output logic             osc_irq
);
    logic [7:0] syn_reg;
    logic [7:0] ref_divider_reg;
    logic [7:0] post_divider_reg;
    logic [7:0] flags_reg;
    logic [7:0] flags_next;
    logic [7:0] irqen_reg;
    logic       wlock_reg;
    logic       sysclk_from_pll_reg;
    logic       ext_osc_enable_reg;
    logic       locked_reg;
    logic       locked_next;
    logic       oscq_reg;
    logic       oscq_next;
    logic [1:0] sync1_reg;
    logic [1:0] sync2_reg;
    logic [1:0] sync3_reg;
    logic [1:0] filt_reg;
    logic [7:0] vco_mult_reg;
    logic [4:0] ref_rat_reg;
    logic [1:0] filter_reg;
    logic [5:0] post_rat_reg;
    logic [5:0] post_rat_next;
    logic [6:0] bus_rat_reg;
    logic [2:0] irq_reg;
    logic [31:0] prdata_reg;
    logic       wr;
    logic       syn_ok;
    logic       ref_wr;
    logic       ref_ok;
    logic       post_wr;
    logic       flag_wr;
    logic       ctrl_wr;

    pdl_step_if step ();

    pdl_post_stepper u_stepper
    (
        .pclk    (pclk),
        .presetn (presetn),
        .st      (step.stepper)
    );

    function automatic logic pdl_mapped(input logic [11:0] a);
        pdl_mapped = (a == pdl_pkg::SYN_ADDR) || (a == pdl_pkg::REF_DIVIDER_ADDR) ||
                     (a == pdl_pkg::POST_DIVIDER_ADDR) || (a == pdl_pkg::FLAGS_ADDR) ||
                     (a == pdl_pkg::CTRL_ADDR) || (a == pdl_pkg::IRQEN_ADDR);
    endfunction : pdl_mapped

    function automatic logic [7:0] pdl_read(input logic [11:0] a);
        unique case (a)
            pdl_pkg::SYN_ADDR:     pdl_read = syn_reg;
            pdl_pkg::REF_DIVIDER_ADDR:  pdl_read = ref_divider_reg;
            pdl_pkg::POST_DIVIDER_ADDR: pdl_read = post_divider_reg;
            pdl_pkg::FLAGS_ADDR:   pdl_read = flags_reg;
            pdl_pkg::CTRL_ADDR:    pdl_read = {5'h00, ext_osc_enable_reg, sysclk_from_pll_reg, wlock_reg};
            pdl_pkg::IRQEN_ADDR:   pdl_read = irqen_reg;
            default:               pdl_read = 8'h00;
        endcase
    endfunction : pdl_read

    // Zero wait states; unmapped addresses answer with an error
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !pdl_mapped(paddr);
    assign prdata  = prdata_reg;

    assign wr      = psel && penable && pwrite;
    assign syn_ok  = wr && paddr == pdl_pkg::SYN_ADDR && !wlock_reg && sysclk_from_pll_reg;
    assign ref_wr  = wr && paddr == pdl_pkg::REF_DIVIDER_ADDR;
    assign ref_ok  = ref_wr && !wlock_reg && sysclk_from_pll_reg; // RULE4
    assign post_wr = wr && paddr == pdl_pkg::POST_DIVIDER_ADDR;
    assign flag_wr = wr && paddr == pdl_pkg::FLAGS_ADDR;
    assign ctrl_wr = wr && paddr == pdl_pkg::CTRL_ADDR;

    // Read data captured in the setup phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_reg <= 32'h0000_0000;
        else if (psel && !penable && !pwrite)
            prdata_reg <= {24'h00_0000, pdl_read(paddr)};
    end

    // Configuration registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            syn_reg     <= pdl_pkg::SYN_RST;
            ref_divider_reg  <= pdl_pkg::REF_DIVIDER_RST;
            post_divider_reg <= pdl_pkg::POST_DIVIDER_RST;
            irqen_reg   <= pdl_pkg::IRQEN_RST;
        end
        else
        begin
            if (syn_ok)
                syn_reg <= pwdata[7:0] & pdl_pkg::SYN_MASK;
            if (ref_ok)
                ref_divider_reg <= pwdata[7:0] & pdl_pkg::REF_DIVIDER_MASK; // RULE4
            if (post_wr && sysclk_from_pll_reg)
                post_divider_reg <= pwdata[7:0] & pdl_pkg::POST_DIVIDER_MASK; // RULE9
            if (wr && paddr == pdl_pkg::IRQEN_ADDR)
                irqen_reg <= pwdata[7:0] & pdl_pkg::IRQEN_MASK;
        end
    end

    // Protection, oscillator enable and clock select
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wlock_reg  <= 1'b0;
            ext_osc_enable_reg   <= 1'b0;
            sysclk_from_pll_reg <= 1'b1;
        end
        else
        begin
            if (ctrl_wr)
                wlock_reg <= pwdata[pdl_pkg::WLOCK_BIT];
            if (ctrl_wr && !wlock_reg)
                ext_osc_enable_reg <= pwdata[pdl_pkg::EXT_OSC_ENABLE_BIT];
            if (!oscq_reg || full_stop_entry)
                sysclk_from_pll_reg <= 1'b1; // RULE19
            else if (ctrl_wr && !wlock_reg)
                sysclk_from_pll_reg <= pwdata[pdl_pkg::SYSCLK_FROM_PLL_BIT]; // RULE19
        end
    end

    // Three-stage pin synchronisers, change taken when stages 2 and 3 agree
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1_reg <= 2'b00;
            sync2_reg <= 2'b00;
            sync3_reg <= 2'b00;
            filt_reg  <= 2'b00;
        end
        else
        begin
            sync1_reg <= {osc_good, loop_in_tol};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            filt_reg  <= (~(sync2_reg ^ sync3_reg) & sync3_reg) |
                         ((sync2_reg ^ sync3_reg) & filt_reg);
        end
    end

    // Lock and oscillator status; loop writes force a requalify
    always_comb
    begin
        locked_next = filt_reg[0]; // RULE15
        oscq_next   = filt_reg[1];
        if (syn_ok || ref_ok)
        begin
            locked_next = 1'b0; // RULE1 RULE5
            oscq_next   = 1'b0;
        end
        if (full_stop_entry)
            oscq_next = 1'b0; // RULE17
    end

    // Event flags: hardware set wins over write-one clear
    always_comb
    begin
        flags_next = flags_reg;
        if (flag_wr)
        begin
            flags_next[pdl_pkg::TICK_BIT]    = flags_reg[pdl_pkg::TICK_BIT] &
                                               ~pwdata[pdl_pkg::TICK_BIT]; // RULE13
            flags_next[pdl_pkg::LOCKCHG_BIT] = flags_reg[pdl_pkg::LOCKCHG_BIT] &
                                               ~pwdata[pdl_pkg::LOCKCHG_BIT];
            flags_next[pdl_pkg::OSCCHG_BIT]  = flags_reg[pdl_pkg::OSCCHG_BIT] &
                                               ~pwdata[pdl_pkg::OSCCHG_BIT];
        end
        if (tick_end)
            flags_next[pdl_pkg::TICK_BIT] = 1'b1; // RULE13
        if (locked_next != locked_reg)
            flags_next[pdl_pkg::LOCKCHG_BIT] = 1'b1; // RULE14
        if (oscq_next != oscq_reg)
            flags_next[pdl_pkg::OSCCHG_BIT] = 1'b1; // RULE16
        flags_next[pdl_pkg::LOCKED_BIT] = locked_next; // RULE15
        flags_next[pdl_pkg::OSCQ_BIT]   = oscq_next; // RULE17
        flags_next[6:5] = 2'b00; // RULE20
        flags_next[2]   = 1'b0; // RULE20
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            flags_reg  <= 8'h00;
            locked_reg <= 1'b0;
            oscq_reg   <= 1'b0;
            irq_reg    <= 3'b000;
        end
        else
        begin
            flags_reg  <= flags_next;
            locked_reg <= locked_next;
            oscq_reg   <= oscq_next;
            irq_reg    <= {flags_next[pdl_pkg::TICK_BIT] & irqen_reg[pdl_pkg::TICK_BIT],
                           flags_next[pdl_pkg::LOCKCHG_BIT] & irqen_reg[pdl_pkg::LOCKCHG_BIT],
                           flags_next[pdl_pkg::OSCCHG_BIT] &
                           irqen_reg[pdl_pkg::OSCCHG_BIT]}; // RULE18
        end
    end

    // Divider ratios presented to the clock path
    assign step.locked = locked_reg;
    assign step.target = locked_reg ? post_divider_reg[4:0] : pdl_pkg::UNLOCK_DIV; // RULE10
    assign post_rat_next = {1'b0, step.cur} + 6'h01; // RULE10

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            vco_mult_reg <= pdl_pkg::VCO_MULT_RST;
            ref_rat_reg  <= pdl_pkg::REF_RAT_RST;
            filter_reg   <= 2'b00;
            post_rat_reg <= pdl_pkg::POST_RAT_RST;
            bus_rat_reg  <= pdl_pkg::BUS_RAT_RST;
        end
        else
        begin
            vco_mult_reg <= ((syn_reg & pdl_pkg::MULT_MASK) + 8'h01) << 1; // RULE2
            ref_rat_reg  <= ext_osc_enable_reg ? {1'b0, ref_divider_reg[3:0]} + 5'h01 : 5'h01; // RULE6
            filter_reg   <= ext_osc_enable_reg ? ref_divider_reg[7:6] : 2'b00; // RULE8
            post_rat_reg <= post_rat_next;
            bus_rat_reg  <= {post_rat_next, 1'b0}; // RULE11
        end
    end

    assign pll_locked       = locked_reg;
    assign osc_qualified    = oscq_reg;
    assign sysclk_from_pll  = sysclk_from_pll_reg;
    assign cfg_write_lock   = wlock_reg;
    assign ext_osc_enable   = ext_osc_enable_reg;
    assign vco_range_sel    = syn_reg[7:6];
    assign vco_mult         = vco_mult_reg;
    assign ref_div_ratio    = ref_rat_reg;
    assign ref_filter_range = filter_reg;
    assign pll_post_ratio   = post_rat_reg;
    assign bus_ratio        = bus_rat_reg;
    assign tick_irq         = irq_reg[2];
    assign lock_irq         = irq_reg[1];
    assign osc_irq          = irq_reg[0];

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_unlocked_two;
        !locked_reg [*2];
    endsequence

    chk_syn_write_clears: assert property ( // RULE1
        syn_ok |=> !locked_reg && !oscq_reg)
        else $error("synthesizer write left status set");
    chk_vco_mult_value: assert property ( // RULE2
        vco_mult_reg == ((($past(syn_reg) & 8'h3f) + 8'h01) << 1))
        else $error("loop multiplier ratio wrong");
    chk_ref_divider_gated: assert property ( // RULE4
        ref_wr && (wlock_reg || !sysclk_from_pll_reg) |=> $stable(ref_divider_reg))
        else $error("blocked reference divider write took effect");
    chk_ref_divider_clears: assert property ( // RULE5
        ref_ok |=> !locked_reg && !oscq_reg)
        else $error("reference divider write left status set");
    chk_filter_fixed: assert property ( // RULE8
        !ext_osc_enable_reg |=> filter_reg == 2'b00)
        else $error("filter range not fixed on internal reference");
    chk_post_divider_gated: assert property ( // RULE9
        post_wr && !sysclk_from_pll_reg |=> $stable(post_divider_reg))
        else $error("blocked post divider write took effect");
    chk_unlocked_ratio: assert property ( // RULE10
        s_unlocked_two |=> post_rat_reg == 6'h04)
        else $error("unlocked ratio not four");
    chk_bus_half: assert property ( // RULE11
        bus_rat_reg == {post_rat_reg, 1'b0})
        else $error("bus ratio not twice pll ratio");
    chk_tick_sets: assert property ( // RULE13
        tick_end |=> flags_reg[7])
        else $error("tick flag not set");
    chk_lock_flag: assert property ( // RULE14
        $changed(locked_reg) |-> flags_reg[4])
        else $error("lock change flag not set");
    chk_osc_flag: assert property ( // RULE16
        $changed(oscq_reg) |-> flags_reg[1])
        else $error("oscillator change flag not set");
    chk_stop_clears_osc: assert property ( // RULE17
        full_stop_entry |=> !oscq_reg)
        else $error("full stop left oscillator status set");
    chk_stop_selects_pll: assert property ( // RULE19
        full_stop_entry |=> sysclk_from_pll_reg)
        else $error("full stop did not select pll");
    chk_irq_enable: assert property ( // RULE18
        lock_irq |-> ($past(irqen_reg) & 8'h10) != 8'h00)
        else $error("lock request without enable");
    chk_flag_reserved: assert property ( // RULE20
        (flags_reg & 8'h64) == 8'h00)
        else $error("reserved flag bits not zero");
endmodule : pdl_pll_ctrl
`default_nettype wire

// ===== pkg/pdl_pkg.sv
`default_nettype none
package pdl_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0]  SYN_IDX      = 8'h04;
    localparam logic [7:0]  REF_DIVIDER_IDX   = 8'h05;
    localparam logic [7:0]  POST_DIVIDER_IDX  = 8'h06;
    localparam logic [7:0]  FLAGS_IDX    = 8'h07;
    localparam logic [7:0]  CTRL_IDX     = 8'h20;
    localparam logic [7:0]  IRQEN_IDX    = 8'h21;
    localparam logic [11:0] SYN_ADDR     = {2'b00, SYN_IDX, 2'b00};
    localparam logic [11:0] REF_DIVIDER_ADDR  = {2'b00, REF_DIVIDER_IDX, 2'b00};
    localparam logic [11:0] POST_DIVIDER_ADDR = {2'b00, POST_DIVIDER_IDX, 2'b00};
    localparam logic [11:0] FLAGS_ADDR   = {2'b00, FLAGS_IDX, 2'b00};
    localparam logic [11:0] CTRL_ADDR    = {2'b00, CTRL_IDX, 2'b00};
    localparam logic [11:0] IRQEN_ADDR   = {2'b00, IRQEN_IDX, 2'b00};
    // Event flag register bit positions
    localparam int TICK_BIT    = 7;
    localparam int LOCKCHG_BIT = 4;
    localparam int LOCKED_BIT  = 3;
    localparam int OSCCHG_BIT  = 1;
    localparam int OSCQ_BIT    = 0;
    // Control register bit positions
    localparam int WLOCK_BIT   = 0;
    localparam int SYSCLK_FROM_PLL_BIT  = 1;
    localparam int EXT_OSC_ENABLE_BIT    = 2;
    // Field masks
    localparam logic [7:0] SYN_MASK     = 8'hff;
    localparam logic [7:0] MULT_MASK    = 8'h3f;
    localparam logic [7:0] REF_DIVIDER_MASK  = 8'hcf;
    localparam logic [7:0] POST_DIVIDER_MASK = 8'h1f;
    localparam logic [7:0] IRQEN_MASK   = 8'h92;
    // Values after reset
    localparam logic [7:0] SYN_RST      = 8'h00;
    localparam logic [7:0] REF_DIVIDER_RST   = 8'h00;
    localparam logic [7:0] POST_DIVIDER_RST  = 8'h00;
    localparam logic [7:0] IRQEN_RST    = 8'h00;
    localparam logic [4:0] UNLOCK_DIV   = 5'h03;
    localparam logic [7:0] VCO_MULT_RST = 8'h02;
    localparam logic [4:0] REF_RAT_RST  = 5'h01;
    localparam logic [5:0] POST_RAT_RST = 6'h04;
    localparam logic [6:0] BUS_RAT_RST  = 7'h08;
    // Post divider settles within this many bus cycles
    localparam int STEP_MAX_CYCLES = 32;
endpackage : pdl_pkg
`default_nettype wire

// ===== pkg/pdl_step_if.sv
`default_nettype none
interface pdl_step_if;
    logic       locked;
    logic [4:0] target;
    logic [4:0] cur;
    modport ctrl (output locked, output target, input cur);
    modport stepper (input locked, input target, output cur);
endinterface : pdl_step_if
`default_nettype wire

// ===== rtl/pdl_post_stepper.sv
`default_nettype none
module pdl_post_stepper
(
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Divider target and current value
    pdl_step_if.stepper st
);
    logic [5:0] settle_cnt;
    logic [4:0] target_prev_reg;
    logic       locked_prev_reg;

    // Jump to divide-by-4 when unlocked, else walk one step per cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st.cur <= pdl_pkg::UNLOCK_DIV;
        else if (!st.locked)
            st.cur <= pdl_pkg::UNLOCK_DIV;
        else if (st.cur < st.target)
            st.cur <= st.cur + 5'h01; // RULE12
        else if (st.cur > st.target)
            st.cur <= st.cur - 5'h01; // RULE12
    end

    // Previous target and lock, to spot a move
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            target_prev_reg <= 5'h00;
            locked_prev_reg <= 1'b0;
        end
        else
        begin
            target_prev_reg <= st.target;
            locked_prev_reg <= st.locked;
        end
    end

    // Helper: cycles since target and lock last moved
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            settle_cnt <= 6'h00;
        else if (!st.locked || st.target != target_prev_reg || !locked_prev_reg)
            settle_cnt <= 6'h00;
        else if (settle_cnt != 6'h3f)
            settle_cnt <= settle_cnt + 6'h01;
    end

    chk_step_reaches_target: assert property ( // RULE12
        @(posedge pclk) disable iff (!presetn)
        settle_cnt == 6'(pdl_pkg::STEP_MAX_CYCLES) |-> st.cur == st.target)
        else $error("post divider not at target after 32 cycles");
endmodule : pdl_post_stepper
`default_nettype wire

// ===== tb/pdl_pll_ctrl_tb_top.sv
`default_nettype none
module pdl_pll_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct {logic [11:0] addr; logic [31:0] wdata; logic [31:0] rdata;} pdl_row_t;

    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        loop_in_tol;
    logic        osc_good;
    logic        tick_end;
    logic        full_stop_entry;
    logic        pll_locked;
    logic        osc_qualified;
    logic        sysclk_from_pll;
    logic        cfg_write_lock;
    logic        ext_osc_enable;
    logic [1:0]  vco_range_sel;
    logic [7:0]  vco_mult;
    logic [4:0]  ref_div_ratio;
    logic [1:0]  ref_filter_range;
    logic [5:0]  pll_post_ratio;
    logic [6:0]  bus_ratio;
    logic        tick_irq;
    logic        lock_irq;
    logic        osc_irq;
    int          err_total;
    int          cmp_count;
    logic [31:0] rd;
    logic        rerr;
    pdl_row_t    rows [6];

    pdl_pll_ctrl i_pdl_pll_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .loop_in_tol(loop_in_tol),
        .osc_good(osc_good), .tick_end(tick_end), .full_stop_entry(full_stop_entry),
        .pll_locked(pll_locked), .osc_qualified(osc_qualified),
        .sysclk_from_pll(sysclk_from_pll), .cfg_write_lock(cfg_write_lock),
        .ext_osc_enable(ext_osc_enable), .vco_range_sel(vco_range_sel),
        .vco_mult(vco_mult), .ref_div_ratio(ref_div_ratio),
        .ref_filter_range(ref_filter_range), .pll_post_ratio(pll_post_ratio),
        .bus_ratio(bus_ratio), .tick_irq(tick_irq), .lock_irq(lock_irq),
        .osc_irq(osc_irq));

    always #50 pclk = ~pclk;

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : report_and_stop

    task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_val

    task automatic cmp_bit(input logic got, input logic exp);
        cmp_val({31'h0, got}, {31'h0, exp});
    endtask : cmp_bit

    task automatic wait_ready;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        cmp_bit(pready, 1'b1);
    endtask : wait_ready

    task automatic apb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        wait_ready();
        rd = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb_xfer

    task automatic apb_write(input logic [11:0] a, input logic [31:0] d);
        apb_xfer(1'b1, a, d);
        #1;
    endtask : apb_write

    task automatic check_reg(input logic [11:0] a, input logic [31:0] exp);
        apb_xfer(1'b0, a, 32'h0);
        cmp_val(rd, exp);
        #1;
    endtask : check_reg

    task automatic cycles(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask : cycles

    task automatic set_pins(input logic tol, input logic osc);
        @(posedge pclk);
        loop_in_tol <= tol;
        osc_good <= osc;
    endtask : set_pins

    initial
    begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        loop_in_tol = 1'b0;
        osc_good = 1'b0;
        tick_end = 1'b0;
        full_stop_entry = 1'b0;
        err_total = 0;
        cmp_count = 0;
        rows[0] = '{pdl_pkg::SYN_ADDR, 32'h45, 32'h45};
        rows[1] = '{pdl_pkg::REF_DIVIDER_ADDR, 32'hff, 32'hcf};
        rows[2] = '{pdl_pkg::POST_DIVIDER_ADDR, 32'he7, 32'h07};
        rows[3] = '{pdl_pkg::IRQEN_ADDR, 32'hff, 32'h92};
        rows[4] = '{pdl_pkg::FLAGS_ADDR, 32'hff, 32'h00};
        rows[5] = '{pdl_pkg::IRQEN_ADDR, 32'h00, 32'h00};
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        cycles(1);
        cmp_bit(sysclk_from_pll, 1'b1);
        cmp_val(pll_post_ratio, 32'h04);
        cmp_val(bus_ratio, 32'h08);
        cmp_val(vco_mult, 32'h02);
        $display("reset test done");
        foreach (rows[i])
        begin
            apb_write(rows[i].addr, rows[i].wdata);
            check_reg(rows[i].addr, rows[i].rdata);
        end
        cmp_val(vco_range_sel, 32'h1);
        cmp_val(vco_mult, 32'h0c);
        cmp_val(ref_div_ratio, 32'h01);
        cmp_val(ref_filter_range, 32'h0);
        $display("table test done");
        apb_xfer(1'b0, 12'h3fc, 32'h0);
        cmp_bit(rerr, 1'b1);
        cmp_val(rd, 32'h0);
        apb_write(pdl_pkg::CTRL_ADDR, 32'h06);
        cmp_bit(ext_osc_enable, 1'b1);
        cmp_bit(cfg_write_lock, 1'b0);
        cycles(2);
        cmp_val(ref_div_ratio, 32'h10);
        cmp_val(ref_filter_range, 32'h3);
        $display("reference test done");
        @(posedge pclk);
        tick_end <= 1'b1;
        @(posedge pclk);
        tick_end <= 1'b0;
        check_reg(pdl_pkg::FLAGS_ADDR, 32'h80);
        cmp_bit(tick_irq, 1'b0);
        apb_write(pdl_pkg::IRQEN_ADDR, 32'h80);
        cycles(2);
        cmp_bit(tick_irq, 1'b1);
        apb_write(pdl_pkg::FLAGS_ADDR, 32'h7f);
        check_reg(pdl_pkg::FLAGS_ADDR, 32'h80);
        apb_write(pdl_pkg::FLAGS_ADDR, 32'h80);
        check_reg(pdl_pkg::FLAGS_ADDR, 32'h00);
        cmp_bit(tick_irq, 1'b0);
        $display("tick test done");
        set_pins(1'b1, 1'b1);
        cycles(8);
        check_reg(pdl_pkg::FLAGS_ADDR, 32'h1b);
        apb_write(pdl_pkg::FLAGS_ADDR, 32'h08);
        check_reg(pdl_pkg::FLAGS_ADDR, 32'h1b);
        apb_write(pdl_pkg::FLAGS_ADDR, 32'h12);
        check_reg(pdl_pkg::FLAGS_ADDR, 32'h09);
        apb_write(pdl_pkg::IRQEN_ADDR, 32'h10);
        cycles(40);
        cmp_val(pll_post_ratio, 32'h08);
        cmp_val(bus_ratio, 32'h10);
        apb_write(pdl_pkg::POST_DIVIDER_ADDR, 32'h1f);
        cycles(3);
        cmp_bit(pll_post_ratio < 6'd32, 1'b1);
        cycles(32);
        cmp_val(pll_post_ratio, 32'h20);
        cmp_val(bus_ratio, 32'h40);
        $display("lock and step test done");
        apb_write(pdl_pkg::SYN_ADDR, 32'h45);
        cmp_bit(pll_locked, 1'b0);
        cmp_bit(osc_qualified, 1'b0);
        cycles(8);
        apb_write(pdl_pkg::FLAGS_ADDR, 32'h12);
        apb_write(pdl_pkg::CTRL_ADDR, 32'h07);
        cmp_bit(cfg_write_lock, 1'b1);
        apb_write(pdl_pkg::REF_DIVIDER_ADDR, 32'h00);
        cmp_bit(pll_locked, 1'b1);
        check_reg(pdl_pkg::REF_DIVIDER_ADDR, 32'hcf);
        apb_write(pdl_pkg::CTRL_ADDR, 32'h06);
        apb_write(pdl_pkg::REF_DIVIDER_ADDR, 32'h41);
        cmp_bit(pll_locked, 1'b0);
        cmp_bit(osc_qualified, 1'b0);
        check_reg(pdl_pkg::REF_DIVIDER_ADDR, 32'h41);
        cycles(8);
        $display("write gating test done");
        apb_write(pdl_pkg::CTRL_ADDR, 32'h04);
        cmp_bit(sysclk_from_pll, 1'b0);
        apb_write(pdl_pkg::POST_DIVIDER_ADDR, 32'h03);
        check_reg(pdl_pkg::POST_DIVIDER_ADDR, 32'h1f);
        apb_write(pdl_pkg::REF_DIVIDER_ADDR, 32'h00);
        check_reg(pdl_pkg::REF_DIVIDER_ADDR, 32'h41);
        @(posedge pclk);
        full_stop_entry <= 1'b1;
        @(posedge pclk);
        full_stop_entry <= 1'b0;
        #1;
        cmp_bit(osc_qualified, 1'b0);
        cmp_bit(sysclk_from_pll, 1'b1);
        cycles(8);
        apb_write(pdl_pkg::CTRL_ADDR, 32'h04);
        cmp_bit(sysclk_from_pll, 1'b0);
        set_pins(1'b0, 1'b0);
        cycles(8);
        cmp_bit(sysclk_from_pll, 1'b1);
        cmp_bit(pll_locked, 1'b0);
        cmp_val(pll_post_ratio, 32'h04);
        cmp_bit(lock_irq, 1'b1);
        cmp_bit(osc_irq, 1'b0);
        $display("clock select test done");
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        cycles(1);
        cmp_bit(cfg_write_lock, 1'b0);
        cmp_bit(ext_osc_enable, 1'b0);
        cmp_bit(sysclk_from_pll, 1'b1);
        cmp_bit(lock_irq, 1'b0);
        cmp_val(pll_post_ratio, 32'h04);
        check_reg(pdl_pkg::POST_DIVIDER_ADDR, 32'h00);
        $display("mid-run reset test done");
        report_and_stop();
    end

    initial
    begin
        repeat (20000) @(posedge pclk);
        err_total++;
        report_and_stop();
    end
endmodule : pdl_pll_ctrl_tb_top
`default_nettype wire
